//--- design/dtpb_pkg.sv
// Purpose: Constants and types for the down timer, PWM and buzzer unit
// Assumes: 32-bit APB, register index times four is the byte address
// Notes:   Indices are kept as printed; decode multiplies by four
package dtpb_pkg;
  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [7:0] IDX_PWM_DUTY_LOW   = 8'h0C;
  localparam logic [7:0] IDX_PRESCALER_CNT  = 8'h0D;
  localparam logic [7:0] IDX_TIMER_HIGH     = 8'h0E;
  localparam logic [7:0] IDX_TIMER_CNT_LOW  = 8'h10;
  localparam logic [7:0] IDX_TIMER_CTRL_ONE = 8'h11;
  localparam logic [7:0] IDX_TIMER_CTRL_TWO = 8'h12;
  localparam logic [7:0] IDX_BUZZER_CTRL    = 8'h15;
  localparam int         ADDR_W             = 8;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          CTL_EN_BIT    = 0;
  localparam int          CTL_RL_BIT    = 1;
  localparam int          CTL_OS_BIT    = 2;
  localparam int          CTL_AL_BIT    = 6;
  localparam int          CTL_OEN_BIT   = 7;
  localparam int          HI_RELOAD_LSB = 4;
  localparam int          HI_DUTY_LSB   = 2;
  localparam int          C2_NDIS_BIT   = 3;
  localparam int          BZ_EN_BIT     = 7;
  localparam logic [7:0]  PRESC_RESET   = 8'hFF;
  localparam logic [3:0]  BZ_SEL_RESET  = 4'hF;
  localparam logic [2:0]  PS_SEL_RESET  = 3'h7;
  localparam logic [9:0]  CNT_FULL      = 10'h3FF;
  localparam logic [9:0]  CNT_ZERO      = 10'h000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic pwm_output_enable;
    logic pwm_active_low;
    logic one_shot;
    logic reload_mode;
    logic timer_enable;
  } dtpb_ctl_t;

  typedef struct packed {
    logic       buzzer_enable;
    logic [3:0] buzzer_freq_select;
  } dtpb_bz_t;

  typedef struct packed {
    logic       out;
    logic       oe;
  } dtpb_pin_t;

  typedef enum logic [1:0] {TS_IDLE, TS_RUN, TS_DONE} dtpb_state_t;
endpackage

//--- design/dtpb_top.sv
// Purpose: 10-bit down timer with prescaler, PWM and buzzer, APB slave
// Assumes: Single clock pclk at 200 MHz, timer counts prescaler ticks
// Notes:   Zero wait state bus; read data sampled in the setup cycle
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module dtpb_top (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [dtpb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // General-purpose pin logic on the same clock
  input  wire logic                      gpio_out,
  input  wire logic                      gpio_oe,
  // Shared PWM pin and buzzer
  output dtpb_pkg::dtpb_pin_t            pwm_pin,
  output logic                           buzzer_out
);
  import dtpb_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  dtpb_ctl_t   ctl_r;
  dtpb_bz_t    bz_r;
  dtpb_state_t state_r;
  logic [7:0]  duty_low_r;
  logic [7:0]  reload_low_r;
  logic [7:0]  high_r;
  logic [2:0]  ps_sel_r;
  logic        ps_dis_r;
  logic [7:0]  presc_r;
  logic [9:0]  cnt_r;
  logic [31:0] prdata_r;
  logic [7:0]  rd_byte;
  logic [9:0]  reload_val;
  logic [9:0]  duty_val;
  logic [7:0]  idx;
  logic        addr_ok;
  logic        wr_acc;
  logic        cnt_wr;
  logic        tick;
  logic        underflow;
  logic        pwm_active;
  logic        pwm_level;
  logic        bz_src;
  logic [8:0]  tick_mask;

  assign idx     = {2'h0, paddr[ADDR_W-1:2]};
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (idx == IDX_PWM_DUTY_LOW   || idx == IDX_PRESCALER_CNT ||
                    idx == IDX_TIMER_HIGH     || idx == IDX_TIMER_CNT_LOW ||
                    idx == IDX_TIMER_CTRL_ONE || idx == IDX_TIMER_CTRL_TWO ||
                    idx == IDX_BUZZER_CTRL);
  assign wr_acc  = psel && penable && pwrite && addr_ok;
  assign cnt_wr  = wr_acc && (idx == IDX_TIMER_CNT_LOW);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_r;

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
    end else if (wr_acc && idx == IDX_TIMER_CTRL_ONE) begin
      ctl_r.pwm_output_enable <= pwdata[CTL_OEN_BIT];
      ctl_r.pwm_active_low    <= pwdata[CTL_AL_BIT];
      ctl_r.one_shot          <= pwdata[CTL_OS_BIT];
      ctl_r.reload_mode       <= pwdata[CTL_RL_BIT];
      ctl_r.timer_enable      <= pwdata[CTL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bz_r.buzzer_enable      <= 1'b0;
      bz_r.buzzer_freq_select <= BZ_SEL_RESET;
    end else if (wr_acc && idx == IDX_BUZZER_CTRL) begin
      bz_r.buzzer_enable      <= pwdata[BZ_EN_BIT];
      bz_r.buzzer_freq_select <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_sel_r <= PS_SEL_RESET;
      ps_dis_r <= 1'b1;
    end else if (wr_acc && idx == IDX_TIMER_CTRL_TWO) begin
      ps_sel_r <= pwdata[2:0];
      ps_dis_r <= pwdata[C2_NDIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_r       <= '0;
      duty_low_r   <= '0;
      reload_low_r <= '0;
    end else if (wr_acc) begin
      if (idx == IDX_TIMER_HIGH) begin
        high_r <= pwdata[7:0];
      end
      if (idx == IDX_PWM_DUTY_LOW) begin
        duty_low_r <= pwdata[7:0];
      end
      if (idx == IDX_TIMER_CNT_LOW) begin
        reload_low_r <= pwdata[7:0];
      end
    end
  end

  // Reload and duty are both ten bits wide
  assign reload_val = {high_r[HI_RELOAD_LSB+1:HI_RELOAD_LSB],
                       reload_low_r};
  assign duty_val   = {high_r[HI_DUTY_LSB+1:HI_DUTY_LSB], duty_low_r};

  // ************************************************************
  // Prescaler
  // ************************************************************
  // Free-running down count; tick when the low sel+1 bits reach zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= PRESC_RESET;
    end else if (!ps_dis_r) begin
      presc_r <= presc_r - 8'h01;
    end
  end

  assign tick_mask = (9'h002 << ps_sel_r) - 9'h001;
  // Disabled prescaler is bypassed so the timer sees every clock
  assign tick = ps_dis_r ||
                ((presc_r & tick_mask[7:0]) == 8'h00);

  // ************************************************************
  // Down counter
  // ************************************************************
  assign underflow = tick && ctl_r.timer_enable && state_r == TS_RUN &&
                     cnt_r == CNT_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CNT_ZERO;
    end else if (cnt_wr) begin
      cnt_r <= {high_r[HI_RELOAD_LSB+1:HI_RELOAD_LSB], pwdata[7:0]};
    end else if (tick && ctl_r.timer_enable && state_r == TS_RUN) begin
      if (cnt_r != CNT_ZERO) begin
        cnt_r <= cnt_r - 10'h001;
      end else if (!ctl_r.one_shot) begin
        cnt_r <= ctl_r.reload_mode ? reload_val : CNT_FULL;
      end
    end
  end

  // One-shot stop is held until the counter is written again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TS_IDLE;
    end else begin
      case (state_r)
        TS_IDLE: begin
          if (ctl_r.timer_enable || cnt_wr) begin
            state_r <= TS_RUN;
          end
        end
        TS_RUN: begin
          if (cnt_wr) begin
            state_r <= TS_RUN;
          end else if (underflow && ctl_r.one_shot) begin
            state_r <= TS_DONE;
          end
        end
        TS_DONE: begin
          if (cnt_wr) begin
            state_r <= TS_RUN;
          end
        end
        default: begin
          state_r <= TS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // PWM and pin mux
  // ************************************************************
  assign pwm_active = cnt_r < duty_val;
  assign pwm_level  = pwm_active ^ ctl_r.pwm_active_low;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pin <= '0;
    end else if (ctl_r.pwm_output_enable) begin
      pwm_pin.out <= pwm_level;
      pwm_pin.oe  <= 1'b1;
    end else begin
      pwm_pin.out <= gpio_out;
      pwm_pin.oe  <= gpio_oe;
    end
  end

  // ************************************************************
  // Buzzer
  // ************************************************************
  always_comb begin
    if (bz_r.buzzer_freq_select[3]) begin
      bz_src = cnt_r[bz_r.buzzer_freq_select[2:0]];
    end else begin
      // Bit n of the prescaler toggles at clock / 2^(n+1)
      bz_src = presc_r[bz_r.buzzer_freq_select[2:0]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzzer_out <= 1'b0;
    end else begin
      buzzer_out <= bz_r.buzzer_enable && bz_src;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_PRESCALER_CNT:  rd_byte = presc_r;
      IDX_TIMER_HIGH:     rd_byte = high_r;
      IDX_TIMER_CNT_LOW:  rd_byte = cnt_r[7:0];
      IDX_TIMER_CTRL_ONE: rd_byte = {ctl_r.pwm_output_enable,
                                     ctl_r.pwm_active_low, 3'h0,
                                     ctl_r.one_shot, ctl_r.reload_mode,
                                     ctl_r.timer_enable};
      IDX_TIMER_CTRL_TWO: rd_byte = {4'h0, ps_dis_r, ps_sel_r};
      default:            rd_byte = 8'h00;
    endcase
  end

  // Sampled in setup so prdata comes from a flop at zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {24'h0, rd_byte};
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_cnt_write;
    cnt_wr;
  endsequence
  sequence s_running_tick;
    tick && ctl_r.timer_enable && state_r == TS_RUN && !cnt_wr;
  endsequence

  AST_CNT_WRITE_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
    s_cnt_write |=> cnt_r == {$past(high_r[5:4]), $past(pwdata[7:0])})
    else $error("counter write did not load ten bits");
  AST_DISABLED_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_r.timer_enable && !cnt_wr |=> $stable(cnt_r))
    else $error("counter moved while disabled");
  AST_RELOAD_PROG: assert property (@(posedge pclk) disable iff (!presetn)
    s_running_tick and (cnt_r == CNT_ZERO && !ctl_r.one_shot &&
    ctl_r.reload_mode) |=> cnt_r == $past(reload_val))
    else $error("reload value not taken on underflow");
  AST_RELOAD_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    s_running_tick and (cnt_r == CNT_ZERO && !ctl_r.one_shot &&
    !ctl_r.reload_mode) |=> cnt_r == CNT_FULL)
    else $error("full count not taken on underflow");
  AST_ONE_SHOT_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    s_running_tick and (cnt_r == CNT_ZERO && ctl_r.one_shot)
    |=> state_r == TS_DONE ##1 (cnt_r == CNT_ZERO || $past(cnt_wr)))
    else $error("one-shot did not stop at zero");
  AST_DECREMENT: assert property (@(posedge pclk) disable iff (!presetn)
    s_running_tick and (cnt_r != CNT_ZERO)
    |=> cnt_r == $past(cnt_r) - 10'h001)
    else $error("counter did not decrement on tick");
  AST_PWM_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_r.pwm_output_enable |=> pwm_pin.oe &&
    pwm_pin.out == (($past(cnt_r) < $past(duty_val)) ^
                    $past(ctl_r.pwm_active_low)))
    else $error("pwm pin level wrong");
  AST_BUZZER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !bz_r.buzzer_enable |=> !buzzer_out)
    else $error("buzzer ran while disabled");
  AST_PRESC_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
    !ps_dis_r |=> presc_r == $past(presc_r) - 8'h01)
    else $error("prescaler not counting");
endmodule

//--- verification/dtpb_top_tb.sv
// Purpose: Self-checking bench for the down timer, PWM and buzzer unit
// Assumes: Zero wait APB, read data sampled at the setup edge
// Notes:   Windows are sized so that tick and toggle counts come out whole
`timescale 1ns/1ps
module dtpb_top_tb;
  import dtpb_pkg::*;
  localparam int LIMIT = 20000;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic [31:0]       rdv;
  logic              pready;
  logic              pslverr;
  logic              errv;
  logic              gpio_out = 1'b1;
  logic              gpio_oe = 1'b1;
  dtpb_pin_t         pwm_pin;
  logic              buzzer_out;
  int                err_total = 0;
  int                compares = 0;
  int                cyc = 0;

  dtpb_top dtpb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pwm_pin(pwm_pin),
    .buzzer_out(buzzer_out));

  always #2.5 pclk = ~pclk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test();
    $display("Compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("BAD %0t run did not complete", $time);
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // Request held until the edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    apb(1'b0, IDX_PRESCALER_CNT, 8'h00);
    chk8(rdv[7:0], PRESC_RESET);
    apb(1'b1, IDX_PRESCALER_CNT, 8'h00);
    apb(1'b0, IDX_PRESCALER_CNT, 8'h00);
    chk8(rdv[7:0], PRESC_RESET);
    apb(1'b0, IDX_TIMER_CTRL_ONE, 8'h00);
    chk8(rdv[7:0], 8'h00);
    chk1(buzzer_out, 1'b0);
    chk1(pwm_pin.oe, 1'b1);
    chk1(pwm_pin.out, 1'b1);
    apb(1'b0, 8'h3F, 8'h00);
    chk1(errv, 1'b1);
    chk8(rdv[7:0], 8'h00);
  endtask

  // Frozen counter 0x35A compared against duty one above it and equal to it
  task automatic t_pwm();
    apb(1'b1, IDX_TIMER_HIGH, 8'h3C);
    apb(1'b1, IDX_TIMER_CNT_LOW, 8'h5A);
    apb(1'b1, IDX_PWM_DUTY_LOW, 8'h5B);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h80);
    repeat (2) @(posedge pclk);
    chk1(pwm_pin.oe, 1'b1);
    chk1(pwm_pin.out, 1'b1);
    apb(1'b1, IDX_PWM_DUTY_LOW, 8'h5A);
    repeat (2) @(posedge pclk);
    chk1(pwm_pin.out, 1'b0);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'hC0);
    repeat (2) @(posedge pclk);
    chk1(pwm_pin.out, 1'b1);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
    gpio_out <= 1'b0;
    gpio_oe  <= 1'b0;
    repeat (2) @(posedge pclk);
    chk1(pwm_pin.oe, 1'b0);
    chk1(pwm_pin.out, 1'b0);
    apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
    chk8(rdv[7:0], 8'h5A);
  endtask

  // Prescaler off after reset, so the timer ticks every clock
  task automatic t_modes();
    apb(1'b1, IDX_TIMER_HIGH, 8'h00);
    apb(1'b1, IDX_TIMER_CNT_LOW, 8'h05);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h07);
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
    chk8(rdv[7:0], 8'h00);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
    apb(1'b1, IDX_TIMER_CNT_LOW, 8'h05);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h03);
    repeat (37) @(posedge pclk);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
    apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
    chk1(rdv[7:0] <= 8'h05, 1'b1);
    apb(1'b1, IDX_TIMER_CNT_LOW, 8'h03);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h01);
    repeat (10) @(posedge pclk);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
    apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
    chk1(rdv[7:0] >= 8'hE0, 1'b1);
    // Write while running wins; three ticks follow in the disable write
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h01);
    apb(1'b1, IDX_TIMER_CNT_LOW, 8'h40);
    apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
    apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
    chk8(rdv[7:0], 8'h3D);
  endtask

  // Each select should give eight ticks, give or take the bus cycles
  task automatic t_presc();
    logic [7:0] first;
    logic [7:0] gone;
    apb(1'b1, IDX_TIMER_CTRL_TWO, 8'h07);
    apb(1'b0, IDX_PRESCALER_CNT, 8'h00);
    first = rdv[7:0];
    apb(1'b0, IDX_PRESCALER_CNT, 8'h00);
    chk1(rdv[7:0] !== first, 1'b1);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, IDX_TIMER_CNT_LOW, 8'hFF);
      apb(1'b1, IDX_TIMER_CTRL_TWO, 8'(s));
      apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h01);
      repeat (8 << (s + 1)) @(posedge pclk);
      apb(1'b1, IDX_TIMER_CTRL_ONE, 8'h00);
      apb(1'b0, IDX_TIMER_CNT_LOW, 8'h00);
      gone = 8'hFF - rdv[7:0];
      chk1(gone >= 8'h07 && gone <= 8'h0A, 1'b1);
    end
  endtask

  task automatic t_buzz();
    logic [7:0] pat;
    logic       prev;
    int         rises;
    pat = 8'hA5;
    apb(1'b1, IDX_TIMER_CNT_LOW, pat);
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, IDX_BUZZER_CTRL, 8'h88 | 8'(n));
      repeat (2) @(posedge pclk);
      chk1(buzzer_out, pat[n]);
    end
    apb(1'b1, IDX_BUZZER_CTRL, 8'h08);
    repeat (2) @(posedge pclk);
    chk1(buzzer_out, 1'b0);
    apb(1'b1, IDX_TIMER_CTRL_TWO, 8'h07);
    // Window of eight periods: rise count is exact at any phase
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, IDX_BUZZER_CTRL, 8'h80 | 8'(n));
      repeat (4) @(posedge pclk);
      prev = buzzer_out;
      rises = 0;
      repeat (8 << (n + 1)) begin
        @(posedge pclk);
        if (buzzer_out === 1'b1 && prev === 1'b0) rises++;
        prev = buzzer_out;
      end
      chk1(rises == 8, 1'b1);
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pwm();
    t_modes();
    t_presc();
    t_buzz();
    finish_test();
  end
endmodule
